/* File: logic/dcsp_port.sv */
`timescale 1ns/10ps
module dcsp_port
    import dcsp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       sclk,
    input  wire logic       csN,
    input  wire logic       sdioIn,
    output logic            sdioOut,
    output logic            sdioOe,
    output logic            serialDataOut,
    output logic            serialDataOutOe,
    output logic [7:0]      cfgReg [DCSP_NREG],
    output logic [7:0]      cfgActive [DCSP_NREG]
);
    // ------------------------------------------------------------
    // link domain: shift engine on sclk, reset by select high
    // ------------------------------------------------------------
    dcsp_phase_t phase_r;
    logic [2:0]  bitCnt_r;
    logic [6:0]  shift_r;
    logic [6:0]  addr_r;
    logic [7:0]  wrByte_r;
    logic [6:0]  wrAddr_r;
    logic        wrTgl_r;
    logic [7:0]  txByte_r;
    logic        txBit_r;
    logic        oeBidir_r;
    logic        oeFour_r;
    logic        cfgBidir_r;
    logic        cfgLsbf_r;

    // mode bits copied onto the link clock at cycle start; quasi-static
    wire logic       lsbFirst = cfgReg[DCSP_COMM_ADR][DCSP_LSBF_BIT];
    wire logic       bidir    = cfgReg[DCSP_COMM_ADR][DCSP_BIDIR_BIT];
    // first rise of a cycle must already shift in the new bit order
    wire logic       lsbNow   = (phase_r == DCSP_INSTR && bitCnt_r == 3'h0)
                                ? lsbFirst : cfgLsbf_r;
    wire logic [7:0] fullByte = lsbNow ? {sdioIn, shift_r}
                                       : {shift_r, sdioIn}; // R9
    wire logic [7:0] instrVal = fullByte;
    wire logic       isRead   = instrVal[DCSP_RW_BIT]; // R3 R12
    wire logic [6:0] startAdr = instrVal[6:0]; // R12
    wire logic       byteDone = bitCnt_r == DCSP_LAST_BIT;
    // no wrap past the end of the map
    wire logic [6:0] nextAdr  = cfgLsbf_r
        ? ((addr_r == DCSP_ADR_MAX) ? addr_r : addr_r + 7'h01)
        : ((addr_r == DCSP_ADR_MIN) ? addr_r : addr_r - 7'h01); // R15
    wire logic [6:0] shiftNxt = lsbNow ? fullByte[7:1] : fullByte[6:0];
    wire logic [6:0] rdAdr    = (phase_r == DCSP_INSTR) ? startAdr : nextAdr;

    always_ff @(posedge sclk or posedge csN)
    begin
        if (csN)
        begin
            phase_r    <= DCSP_INSTR; // R4
            bitCnt_r   <= 3'h0;
            shift_r    <= 7'h00;
            addr_r     <= 7'h00;
            txByte_r   <= 8'h00;
            cfgBidir_r <= 1'b0;
            cfgLsbf_r  <= 1'b0;
        end
        else
        begin
            bitCnt_r <= bitCnt_r + 3'h1;
            shift_r  <= shiftNxt; // R13
            if (phase_r == DCSP_INSTR && bitCnt_r == 3'h0)
            begin
                cfgBidir_r <= bidir;
                cfgLsbf_r  <= lsbFirst;
            end
            if (byteDone)
            begin
                unique case (phase_r)
                    DCSP_INSTR: // R1 R2
                    begin
                        addr_r  <= startAdr;
                        phase_r <= isRead ? DCSP_READ : DCSP_WRITE; // R5
                    end
                    DCSP_WRITE: // R6 R10 R16
                    begin
                        addr_r   <= nextAdr; // R15
                    end
                    DCSP_READ: // R10 R11
                    begin
                        addr_r <= rdAdr;
                    end
                endcase
                // load the byte at the address the next byte slot uses
                if (phase_r == DCSP_READ || (phase_r == DCSP_INSTR && isRead))
                    txByte_r <= cfgReg[rdAdr]; // R11 R15
            end
        end
    end

    // write toggle: separate so a byte only counts when complete
    // hold registers sit outside the select reset: a select release
    // right after the last byte must not clear them while they cross
    always_ff @(posedge sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrTgl_r  <= 1'b0;
            wrByte_r <= 8'h00;
            wrAddr_r <= 7'h00;
        end
        else if (!csN && byteDone && phase_r == DCSP_WRITE)
        begin
            wrByte_r <= fullByte;
            wrAddr_r <= addr_r;
            wrTgl_r  <= ~wrTgl_r; // R6 R16
        end
    end

    // output bit launched on falling edge
    wire logic [2:0] txIdx = cfgLsbf_r ? bitCnt_r : 3'h7 - bitCnt_r;
    always_ff @(negedge sclk or posedge csN)
    begin
        if (csN)
        begin
            txBit_r   <= 1'b0;
            oeBidir_r <= 1'b0; // R14
            oeFour_r  <= 1'b0; // R14
        end
        else
        begin
            txBit_r   <= txByte_r[txIdx]; // R13
            oeBidir_r <= phase_r == DCSP_READ && cfgBidir_r; // R8
            oeFour_r  <= phase_r == DCSP_READ && !cfgBidir_r; // R8
        end
    end

    // enables are flops cleared at once by select high
    always_comb
    begin
        sdioOut         = txBit_r;
        sdioOe          = oeBidir_r; // R8 R14
        serialDataOut   = txBit_r;
        serialDataOutOe = oeFour_r; // R8 R14
    end

    // ------------------------------------------------------------
    // system domain: register file
    // ------------------------------------------------------------
    logic       wrPulse;
    logic [7:0] wrByteS_r;
    logic [6:0] wrAddrS_r;
    logic       wrGo_r;
    dcsp_sync u_sync
    (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .tglIn    (wrTgl_r),
        .pulseOut (wrPulse)
    );
    // byte/address are stable for a whole byte time, far longer than sync
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrByteS_r <= 8'h00;
            wrAddrS_r <= 7'h00;
            wrGo_r    <= 1'b0;
        end
        else
        begin
            wrByteS_r <= wrByte_r;
            wrAddrS_r <= wrAddr_r;
            wrGo_r    <= wrPulse;
        end
    end
    dcsp_regs u_regs
    (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .wrPulse    (wrGo_r),
        .wrAddr     (wrAddrS_r),
        .wrData     (wrByteS_r),
        .regFile    (cfgReg),
        .activeFile (cfgActive)
    );
endmodule

/* File: logic/dcsp_pkg.sv */
// Contract
// R1 - cycle is instruction phase then data phase
// R2 - first eight rising edges carry instruction
// R3 - decode instruction into direction and address
// R4 - select high then low restarts instruction phase
// R5 - later edges move whole data bytes
// R6 - register updates at last bit of byte
// R7 - tuning words apply on update bit
// R8 - one bidirectional pin or two pins
// R9 - msb-first and lsb-first bit orders
// R10 - single and multibyte cycles supported
// R11 - every register readable and writable
// R12 - bit 7 read, bits 6..0 address
// R13 - sample on rise, drive on fall
// R14 - data pins released while select high
// R15 - address steps down msb-first, up lsb-first
// R16 - partial byte at select release discarded
package dcsp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int        DCSP_NREG      = 128;
    localparam logic [6:0] DCSP_COMM_ADR = 7'h00;
    localparam logic [6:0] DCSP_UPD_ADR  = 7'h36;
    localparam logic [6:0] DCSP_TW_LO    = 7'h30;
    localparam logic [6:0] DCSP_TW_HI    = 7'h35;
    localparam int        DCSP_BIDIR_BIT = 7;
    localparam int        DCSP_LSBF_BIT  = 6;
    localparam int        DCSP_UPD_BIT   = 0;
    localparam int        DCSP_RW_BIT    = 7;
    localparam logic [7:0] DCSP_RST_VAL  = 8'h00;
    localparam logic [2:0] DCSP_LAST_BIT = 3'h7;
    localparam logic [6:0] DCSP_ADR_MIN  = 7'h00;
    localparam logic [6:0] DCSP_ADR_MAX  = 7'h7F;
    // ------------------------------------------------------------
    // link phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {DCSP_INSTR, DCSP_WRITE, DCSP_READ} dcsp_phase_t;
endpackage

/* File: logic/dcsp_sync.sv */
`timescale 1ns/10ps
module dcsp_sync
    import dcsp_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic tglIn,
    output logic      pulseOut
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // toggle from link domain becomes one sys_clk pulse
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_r     <= 1'b0;
            s2_r     <= 1'b0;
            s3_r     <= 1'b0;
            pulseOut <= 1'b0;
        end
        else
        begin
            s1_r     <= tglIn;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            pulseOut <= s2_r ^ s3_r;
        end
    end
endmodule

/* File: logic/dcsp_regs.sv */
`timescale 1ns/10ps
module dcsp_regs
    import dcsp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       wrPulse,
    input  wire logic [6:0] wrAddr,
    input  wire logic [7:0] wrData,
    output logic [7:0]      regFile [DCSP_NREG],
    output logic [7:0]      activeFile [DCSP_NREG]
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    function automatic logic isTuning(input logic [6:0] a);
        return (a >= DCSP_TW_LO) && (a <= DCSP_TW_HI);
    endfunction
    wire updHit = wrPulse && wrAddr == DCSP_UPD_ADR
                  && wrData[DCSP_UPD_BIT];
    genvar i;
    generate
        for (i = 0; i < DCSP_NREG; i++)
        begin : g_reg
            always_ff @(posedge sys_clk or negedge nrst)
            begin
                if (!nrst)
                    regFile[i] <= DCSP_RST_VAL;
                else if (wrPulse && wrAddr == 7'(i))
                    regFile[i] <= wrData; // R6 R11
            end
            // tuning words stay pending until the update bit
            always_ff @(posedge sys_clk or negedge nrst)
            begin
                if (!nrst)
                    activeFile[i] <= DCSP_RST_VAL;
                else if (!isTuning(7'(i)) || updHit)
                    activeFile[i] <= regFile[i]; // R7
            end
        end
    endgenerate
endmodule

/* File: bench/dcsp_port_sva.sv */
`timescale 1ns/10ps
module dcsp_port_sva
    import dcsp_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       csN,
    input wire logic       sdioOe,
    input wire logic       serialDataOutOe,
    input wire logic [7:0] cfgReg [DCSP_NREG],
    input wire logic [7:0] cfgActive [DCSP_NREG]
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_idle_release: assert property (
        csN |-> !sdioOe && !serialDataOutOe) else $error("pin driven idle");
    a_one_driver: assert property (
        !(sdioOe && serialDataOutOe)) else $error("both pins driven");
    a_bidir_pin: assert property (
        sdioOe |-> cfgReg[DCSP_COMM_ADR][DCSP_BIDIR_BIT])
        else $error("sdio driven in 4-wire mode");
    a_four_wire: assert property (
        serialDataOutOe |-> !cfgReg[DCSP_COMM_ADR][DCSP_BIDIR_BIT])
        else $error("data out driven in bidir mode");
    // tuning word must not move while the update bit stays clear
    a_tw_pending: assert property (
        !cfgReg[DCSP_UPD_ADR][DCSP_UPD_BIT]
        && !$past(cfgReg[DCSP_UPD_ADR][DCSP_UPD_BIT])
        |-> $stable(cfgActive[DCSP_TW_LO])) else $error("tw moved early");
    a_tw_apply: assert property (
        $rose(cfgReg[DCSP_UPD_ADR][DCSP_UPD_BIT])
        |-> ##[0:2] cfgActive[DCSP_TW_LO] == cfgReg[DCSP_TW_LO])
        else $error("tw not applied");
    a_plain_follow: assert property (
        $changed(cfgReg[7'h20]) |-> ##[0:2] cfgActive[7'h20] == cfgReg[7'h20])
        else $error("plain reg not applied");
    a_quiet_idle: assert property (
        csN [*8] |=> $stable(cfgReg[7'h20])) else $error("write while idle");
endmodule
bind dcsp_port dcsp_port_sva chk (.sys_clk, .nrst, .csN, .sdioOe,
    .serialDataOutOe, .cfgReg, .cfgActive);

/* File: bench/dcsp_host.sv */
`timescale 1ns/10ps
module dcsp_host
    import dcsp_pkg::*;
(
    output logic      sclk,
    output logic      csN,
    output wire logic sdioIn,
    input  wire logic sdioOut,
    input  wire logic sdioOe,
    input  wire logic serialDataOut,
    input  wire logic serialDataOutOe
);
    logic drv;
    // once released, drv toggles each bit so a stale level never passes
    assign sdioIn = sdioOe ? sdioOut : drv;
    initial
    begin
        sclk = 1'b0;
        csN = 1'b1;
        drv = 1'b0;
    end
    task automatic xfer(input logic [7:0] ins, input int nbits,
                        input bit lsbf, input bit bidir,
                        inout logic [7:0] d [4]);
        int i;
        int j;
        csN = 1'b0;
        #100;
        for (i = 0; i < nbits; i++)
        begin
            j = lsbf ? i % 8 : 7 - i % 8;
            if (i < 8)
                drv = ins[j];
            else
                drv = ins[DCSP_RW_BIT] ? ~drv : d[i / 8 - 1][j];
            #62.5 sclk = 1'b1;
            if (i >= 8 && ins[DCSP_RW_BIT])
                d[i / 8 - 1][j] = bidir ? (sdioOe ? sdioOut : 1'bx)
                    : (serialDataOutOe ? serialDataOut : 1'bx);
            #62.5 sclk = 1'b0;
        end
        #100 csN = 1'b1;
    endtask
endmodule

/* File: bench/test_dac_config_serial_port.sv */
`timescale 1ns/10ps
module test_dac_config_serial_port
    import dcsp_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    wire        sclk, csN, sdioIn, sdioOut, sdioOe;
    wire        serialDataOut, serialDataOutOe;
    logic [7:0] cfgReg [DCSP_NREG];
    logic [7:0] cfgActive [DCSP_NREG];
    logic [7:0] expReg [DCSP_NREG];
    logic [7:0] d [4];
    logic [6:0] a;
    bit         lf = 1'b0;
    bit         bd = 1'b0;
    int         n_errors = 0;
    int         n_checks = 0;
    int         i;
    dcsp_port dut (.sys_clk, .nrst, .sclk, .csN, .sdioIn, .sdioOut, .sdioOe,
        .serialDataOut, .serialDataOutOe, .cfgReg, .cfgActive);
    dcsp_host host (.sclk, .csN, .sdioIn, .sdioOut, .sdioOe, .serialDataOut,
        .serialDataOutOe);
    initial forever #20 sys_clk = ~sys_clk;
    function automatic logic [6:0] step(input logic [6:0] x, input bit up);
        if (up)
            return (x == DCSP_ADR_MAX) ? x : x + 7'h1;
        return (x == DCSP_ADR_MIN) ? x : x - 7'h1;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // writes land a few system clocks after the byte, so wait ten
    task automatic xf(input bit rd, input logic [6:0] adr, input int n);
        logic [6:0] x;
        int         k;
        x = adr;
        for (k = 0; k < n && !rd; k++)
        begin
            expReg[x] = d[k];
            x = step(x, lf);
        end
        @(negedge sys_clk);
        host.xfer({rd, adr}, 8 + 8 * n, lf, bd, d);
        repeat (10) @(negedge sys_clk);
        x = adr;
        for (k = 0; k < n; k++)
        begin
            check(rd ? d[k] : cfgReg[x], expReg[x]);
            x = step(x, lf);
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        complete_run();
    end
    initial
    begin
        void'($urandom(67));
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk) nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        for (i = 0; i < DCSP_NREG; i++)
        begin
            expReg[i] = DCSP_RST_VAL;
            check(cfgReg[i], DCSP_RST_VAL);
        end
        for (i = 0; i < 4; i++)
        begin
            d[0] = {i[1], i[0], 6'h00};
            xf(1'b0, DCSP_COMM_ADR, 1);
            {bd, lf} = i[1:0];
            foreach (d[k])
                d[k] = 8'($urandom);
            // lsb-first run starts one below the top so the address saturates
            a = lf ? 7'h7E : 7'($urandom_range(47, 16));
            xf(1'b0, a, 3);
            xf(1'b1, a, 3);
        end
        d[0] = ~expReg[7'h20];
        @(negedge sys_clk);
        host.xfer(8'h20, 13, lf, bd, d);
        repeat (10) @(negedge sys_clk);
        check(cfgReg[7'h20], expReg[7'h20]);
        d[0] = 8'hA5;
        xf(1'b0, DCSP_TW_LO, 1);
        check(cfgActive[DCSP_TW_LO], DCSP_RST_VAL);
        d[0] = 8'h01;
        xf(1'b0, DCSP_UPD_ADR, 1);
        check(cfgActive[DCSP_TW_LO], 8'hA5);
        check(cfgActive[7'h20], expReg[7'h20]);
        complete_run();
    end
endmodule
